// >>> alert_host.sv
// Host model: byte-wide register writes and reads into the alert output block.
// Assumes one bench process calls wr and rd one after another.
`timescale 1ns/100ps
`default_nettype none

module alert_host (
    // Clock
    input  wire logic       core_clk,
    // Register access
    output logic      [7:0] reg_addr,
    output logic            reg_wr_en,
    output logic      [7:0] reg_wr_data,
    output logic            reg_rd_en,
    input  wire logic [7:0] reg_rd_data,
    input  wire logic       reg_rd_valid
);
    initial begin
        reg_addr    = 8'h00;
        reg_wr_en   = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en   = 1'b0;
    end

    // Released data line shows the inverse of the last byte
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr    <= a;
        reg_wr_data <= d;
        reg_wr_en   <= 1'b1;
        @(posedge core_clk);
        reg_wr_en   <= 1'b0;
        reg_wr_data <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d  = 8'hxx;
        @(posedge core_clk);
        reg_addr  <= a;
        reg_rd_en <= 1'b1;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge core_clk);
            if (reg_rd_valid === 1'b1) begin
                ok = 1'b1;
                d  = reg_rd_data;
            end
        end
    endtask : rd
endmodule : alert_host
`default_nettype wire

// >>> alert_output_defs.svh
// Register addresses, reset values and field sizes for the alert-driven output block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef ALERT_OUTPUT_DEFS_SVH
`define ALERT_OUTPUT_DEFS_SVH

`define CHANNEL_COUNT      8
`define ADDR_WIDTH         8
`define DATA_WIDTH         8
`define FIRST_MASKED_OUT   3
`define OUT3_MASK_ADDR     8'hc9
`define OUT4_MASK_ADDR     8'hcb
`define OUT5_MASK_ADDR     8'hcd
`define OUT6_MASK_ADDR     8'hcf
`define OUT7_MASK_ADDR     8'hd1
`define UPDATE_ENABLE_ADDR 8'he9
`define DRIVE_LEVEL_ADDR   8'heb
`define MASK_RESET         8'h00
`define ENABLE_RESET       8'h00
`define LEVEL_RESET        8'h00
`define OUTPUT_RESET       8'h00
`define UNMAPPED_READ      8'h00

`endif

// >>> alert_output_pkg.sv
// Types and address decode shared by the alert-driven output block.
// Assumes the constants header is on the include path.
`include "alert_output_defs.svh"

package alert_output_pkg;

    typedef enum logic [1:0] {
        MODE_ANALOG_IN,
        MODE_DIGITAL_IN,
        MODE_OPEN_DRAIN,
        MODE_PUSH_PULL
    } pin_mode_e;

    typedef logic [`DATA_WIDTH-1:0] reg_byte_t;

    typedef struct packed {
        logic       hit;
        logic [2:0] slot;
    } mask_sel_s;

    // Maps an address to the output whose source mask lives there
    function automatic mask_sel_s mask_decode(input logic [`ADDR_WIDTH-1:0] addr);
        mask_sel_s sel;
        sel = '{hit: 1'b1, slot: 3'd0};
        case (addr)
            `OUT3_MASK_ADDR: sel.slot = 3'd3;
            `OUT4_MASK_ADDR: sel.slot = 3'd4;
            `OUT5_MASK_ADDR: sel.slot = 3'd5;
            `OUT6_MASK_ADDR: sel.slot = 3'd6;
            `OUT7_MASK_ADDR: sel.slot = 3'd7;
            default:         sel.hit  = 1'b0;
        endcase
        return sel;
    endfunction : mask_decode

endpackage : alert_output_pkg

// >>> alert_output_unit.sv
// One digital output updated by selected channel alert flags.
// Assumes alert flags and control come from the core clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "alert_output_defs.svh"

module alert_output_unit #(
    parameter int CHANNELS = `CHANNEL_COUNT
) (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                resetn,
    // Configuration
    input  wire logic [CHANNELS-1:0] alert_flags,
    input  wire logic [CHANNELS-1:0] source_mask,
    input  wire logic                update_enable,
    input  wire logic                drive_level,
    // Direct write from elsewhere in the core
    input  wire logic                direct_we,
    input  wire logic                direct_value,
    // Result
    output logic                     out_level,
    output logic                     fire
);

    logic selected;
    logic selected_q;

    assign selected = |(alert_flags & source_mask);
    assign fire     = update_enable & selected & ~selected_q;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            selected_q <= 1'b0;
        end else begin
            selected_q <= selected;
        end
    end

    // Trigger wins over a direct write in the same cycle
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            out_level <= 1'b0;
        end else if (fire) begin
            out_level <= drive_level;
        end else if (direct_we) begin
            out_level <= direct_value;
        end
    end

endmodule : alert_output_unit

`default_nettype wire

// >>> alert_triggered_output_update.sv
// Alert-triggered update of eight digital outputs, with its registers and pin drive.
// Assumes a serial register decoder in the core supplies byte-wide register accesses.
`timescale 1ns/100ps
`default_nettype none
`include "alert_output_defs.svh"

module alert_triggered_output_update
    import alert_output_pkg::*;
#(
    parameter int CHANNELS = `CHANNEL_COUNT
) (
    // Clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     resetn,
    // Register access from the serial decoder
    input  wire logic [`ADDR_WIDTH-1:0]   reg_addr,
    input  wire logic                     reg_wr_en,
    input  wire logic [`DATA_WIDTH-1:0]   reg_wr_data,
    input  wire logic                     reg_rd_en,
    output logic      [`DATA_WIDTH-1:0]   reg_rd_data,
    output logic                          reg_rd_valid,
    // Alert flags and masks held elsewhere
    input  wire logic [CHANNELS-1:0]      alert_flags,
    input  wire logic [3*CHANNELS-1:0]    low_source_masks,
    // Pin configuration, two bits per channel
    input  wire logic [2*CHANNELS-1:0]    channel_pin_mode,
    // Direct output writes
    input  wire logic [CHANNELS-1:0]      direct_out_we,
    input  wire logic [CHANNELS-1:0]      direct_out_value,
    // Channel pins
    input  wire logic [CHANNELS-1:0]      channel_pin_in,
    output logic      [CHANNELS-1:0]      channel_pin_out,
    output logic      [CHANNELS-1:0]      channel_pin_oe,
    // Output state
    output logic      [CHANNELS-1:0]      digital_outputs,
    output logic      [CHANNELS-1:0]      digital_inputs,
    output logic      [CHANNELS-1:0]      alert_update_fired
);

    reg_byte_t                 mask_q [`FIRST_MASKED_OUT:CHANNELS-1];
    reg_byte_t                 mask_src [CHANNELS];
    logic      [CHANNELS-1:0]  enable_q;
    logic      [CHANNELS-1:0]  level_q;
    logic      [CHANNELS-1:0]  out_bits;
    logic      [CHANNELS-1:0]  fire_bits;
    reg_byte_t                 rd_data_d;
    mask_sel_s                 wr_sel;
    mask_sel_s                 rd_sel;

    assign wr_sel = mask_decode(reg_addr);
    assign rd_sel = wr_sel;

    // Masks of outputs below the first masked one come from outside
    genvar k;
    generate
        for (k = 0; k < CHANNELS; k++) begin : g_mask
            if (k < `FIRST_MASKED_OUT) begin : g_ext
                assign mask_src[k] = low_source_masks[k*CHANNELS +: CHANNELS];
            end else begin : g_reg
                always_ff @(posedge core_clk) begin
                    if (!resetn) begin
                        mask_q[k] <= `MASK_RESET;
                    end else if (reg_wr_en && wr_sel.hit && wr_sel.slot == 3'(k)) begin
                        mask_q[k] <= reg_wr_data;
                    end
                end
                assign mask_src[k] = mask_q[k];
            end
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            enable_q <= `ENABLE_RESET;
        end else if (reg_wr_en && reg_addr == `UPDATE_ENABLE_ADDR) begin
            enable_q <= reg_wr_data[CHANNELS-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            level_q <= `LEVEL_RESET;
        end else if (reg_wr_en && reg_addr == `DRIVE_LEVEL_ADDR) begin
            level_q <= reg_wr_data[CHANNELS-1:0];
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_data_d = `UNMAPPED_READ;
        if (rd_sel.hit) begin
            rd_data_d = mask_src[rd_sel.slot];
        end else if (reg_addr == `UPDATE_ENABLE_ADDR) begin
            rd_data_d = enable_q;
        end else if (reg_addr == `DRIVE_LEVEL_ADDR) begin
            rd_data_d = level_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            reg_rd_data  <= `UNMAPPED_READ;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rd_data <= rd_data_d;
            end
        end
    end

    // Level only reaches an output through its enable bit
    generate
        for (k = 0; k < CHANNELS; k++) begin : g_out
            alert_output_unit #(
                .CHANNELS      (CHANNELS)
            ) u_unit (
                .core_clk      (core_clk),
                .resetn        (resetn),
                .alert_flags   (alert_flags),
                .source_mask   (mask_src[k]),
                .update_enable (enable_q[k]),
                .drive_level   (level_q[k]),
                .direct_we     (direct_out_we[k]),
                .direct_value  (direct_out_value[k]),
                .out_level     (out_bits[k]),
                .fire          (fire_bits[k])
            );
        end
    endgenerate

    assign digital_outputs    = out_bits;
    assign alert_update_fired = fire_bits;

    // Pin drive per channel mode
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            channel_pin_out <= `OUTPUT_RESET;
            channel_pin_oe  <= `OUTPUT_RESET;
            digital_inputs  <= `OUTPUT_RESET;
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                case (pin_mode_e'(channel_pin_mode[2*c +: 2]))
                    MODE_PUSH_PULL: begin
                        channel_pin_out[c] <= out_bits[c];
                        channel_pin_oe[c]  <= 1'b1;
                        digital_inputs[c]  <= 1'b0;
                    end
                    MODE_OPEN_DRAIN: begin
                        channel_pin_out[c] <= 1'b0;
                        channel_pin_oe[c]  <= ~out_bits[c];
                        digital_inputs[c]  <= 1'b0;
                    end
                    MODE_DIGITAL_IN: begin
                        channel_pin_out[c] <= 1'b0;
                        channel_pin_oe[c]  <= 1'b0;
                        digital_inputs[c]  <= channel_pin_in[c];
                    end
                    default: begin
                        channel_pin_out[c] <= 1'b0;
                        channel_pin_oe[c]  <= 1'b0;
                        digital_inputs[c]  <= 1'b0;
                    end
                endcase
            end
        end
    end

    chk_mask_write_lands: assert property (
        @(posedge core_clk) disable iff (!resetn)
        reg_wr_en && reg_addr == `OUT5_MASK_ADDR |=> mask_q[5] == $past(reg_wr_data))
        else $error("Output 5 mask did not take the written byte");

    chk_unselected_no_fire: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (alert_flags & mask_q[4]) == 8'h00 |-> !fire_bits[4])
        else $error("Output 4 fired with no selected alert");

    chk_disabled_output_hold: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !enable_q[6] && !direct_out_we[6] |=> $stable(out_bits[6]))
        else $error("Disabled output 6 changed");

    chk_level_write_lands: assert property (
        @(posedge core_clk) disable iff (!resetn)
        reg_wr_en && reg_addr == `DRIVE_LEVEL_ADDR |=> level_q == $past(reg_wr_data))
        else $error("Drive level register did not take the written byte");

    chk_reset_clears_config: assert property (
        @(posedge core_clk)
        !resetn |=> enable_q == 8'h00 && level_q == 8'h00 && mask_q[3] == 8'h00
                    && mask_q[7] == 8'h00 && digital_outputs == 8'h00)
        else $error("Configuration not zero after reset");

    chk_pushpull_pin_drive: assert property (
        @(posedge core_clk) disable iff (!resetn)
        channel_pin_mode[1:0] == 2'b11 |=> channel_pin_oe[0]
                                           && channel_pin_out[0] == $past(out_bits[0]))
        else $error("Push-pull pin 0 not driving its output");

    chk_enable_readback: assert property (
        @(posedge core_clk) disable iff (!resetn)
        reg_rd_en && reg_addr == `UPDATE_ENABLE_ADDR |=> reg_rd_valid
                                                          && reg_rd_data == $past(enable_q))
        else $error("Enable register read back wrong");

    generate
        for (k = 0; k < CHANNELS; k++) begin : g_chk
            chk_selected_rise_fires: assert property (
                @(posedge core_clk) disable iff (!resetn)
                enable_q[k] && $rose(|(alert_flags & mask_src[k])) |-> fire_bits[k])
                else $error("Selected alert rise did not fire its output");

            chk_fire_sets_level: assert property (
                @(posedge core_clk) disable iff (!resetn)
                fire_bits[k] |=> out_bits[k] == $past(level_q[k]) ##1
                                 ($past(fire_bits[k]) || $past(direct_out_we[k])
                                  || $stable(out_bits[k])))
                else $error("Output did not take its drive level on trigger");
        end
    endgenerate

    cov_fire_high: cover property (
        @(posedge core_clk) disable iff (!resetn)
        fire_bits[3] && level_q[3] ##1 out_bits[3]);

    cov_two_outputs_fire: cover property (
        @(posedge core_clk) disable iff (!resetn)
        fire_bits[4] && fire_bits[7]);

    cov_open_drain_low: cover property (
        @(posedge core_clk) disable iff (!resetn)
        channel_pin_mode[7:6] == 2'b10 && !out_bits[3] ##1 channel_pin_oe[3]);

endmodule : alert_triggered_output_update

`default_nettype wire

// >>> alert_triggered_output_update_tb.sv
// Self-checking bench for the alert-triggered output block.
// Assumes the package, the design and the host model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "alert_output_defs.svh"

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
    $display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end

module alert_triggered_output_update_tb
    import alert_output_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        resetn   = 1'b0;
    logic [7:0]  reg_addr, reg_wr_data, reg_rd_data;
    logic        reg_wr_en, reg_rd_en, reg_rd_valid;
    logic [7:0]  alert_flags      = 8'h00;
    logic [7:0]  direct_out_we    = 8'h00;
    logic [7:0]  direct_out_value = 8'h00;
    logic [7:0]  channel_pin_in   = 8'h00;
    logic [15:0] channel_pin_mode = 16'hffff;
    logic [7:0]  channel_pin_out, channel_pin_oe;
    logic [7:0]  digital_outputs, digital_inputs, alert_update_fired;
    int          n_fail      = 0;
    int          checks_done = 0;
    // Row: output, mask, enable, level, alerts, fires
    logic [31:0] rows [6] = '{32'h3011_1011, 32'h4801_0801, 32'h50f1_1f00,
                              32'h6ff0_1ff0, 32'h7241_1041, 32'h3021_0031};

    always #4 core_clk = ~core_clk;

    alert_triggered_output_update dut (
        .core_clk, .resetn, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en,
        .reg_rd_data, .reg_rd_valid, .alert_flags, .low_source_masks(24'h00_0000),
        .channel_pin_mode, .direct_out_we, .direct_out_value, .channel_pin_in,
        .channel_pin_out, .channel_pin_oe, .digital_outputs, .digital_inputs,
        .alert_update_fired
    );

    alert_host host (
        .core_clk, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data,
        .reg_rd_valid
    );

    task automatic stop_test();
        $display("checks %0d, errors %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        host.rd(a, d, ok);
        if (!ok) begin
            n_fail++;
            $display("ERROR %0t: read got no answer", $time);
            stop_test();
        end
        `CHK(d, exp)
    endtask : rd_chk

    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        $display("ERROR %0t: run timed out", $time);
        stop_test();
    end

    initial begin
        logic [3:0] kk;
        logic [7:0] msk, al, maddr;
        logic       en, lvl, fire;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        #1 `CHK(digital_outputs, 8'h00)
        `CHK(channel_pin_oe, 8'h00)
        for (int k = 3; k < 8; k++) rd_chk(8'(`OUT3_MASK_ADDR + 2 * (k - 3)), 8'h00);
        rd_chk(`UPDATE_ENABLE_ADDR, 8'h00);
        rd_chk(`DRIVE_LEVEL_ADDR, 8'h00);
        foreach (rows[i]) begin
            kk    = rows[i][31:28];
            msk   = rows[i][27:20];
            en    = rows[i][16];
            lvl   = rows[i][12];
            al    = rows[i][11:4];
            fire  = rows[i][0];
            maddr = 8'(`OUT3_MASK_ADDR + 2 * (kk - 3));
            host.wr(maddr, msk);
            host.wr(`UPDATE_ENABLE_ADDR, 8'(en) << kk);
            host.wr(`DRIVE_LEVEL_ADDR, 8'(lvl) << kk);
            rd_chk(maddr, msk);
            rd_chk(`DRIVE_LEVEL_ADDR, 8'(lvl) << kk);
            @(posedge core_clk);
            direct_out_we[kk]    <= 1'b1;
            direct_out_value[kk] <= !lvl;
            @(posedge core_clk);
            direct_out_we[kk] <= 1'b0;
            #1 `CHK(digital_outputs[kk], !lvl)
            @(posedge core_clk);
            alert_flags <= al;
            #1 `CHK(alert_update_fired[kk], fire)
            @(posedge core_clk);
            #1 `CHK(digital_outputs[kk], fire ? lvl : !lvl)
            @(posedge core_clk);
            #1 `CHK(channel_pin_out[kk], fire ? lvl : !lvl)
            `CHK(channel_pin_oe[kk], 1'b1)
            @(posedge core_clk);
            alert_flags <= 8'h00;
        end
        // Selected alerts that stay high fire once only
        host.wr(8'(`OUT3_MASK_ADDR + 8), 8'h24);
        host.wr(`UPDATE_ENABLE_ADDR, 8'h80);
        host.wr(`DRIVE_LEVEL_ADDR, 8'h00);
        @(posedge core_clk);
        alert_flags <= 8'h04;
        #1 `CHK(alert_update_fired[7], 1'b1)
        @(posedge core_clk);
        alert_flags <= 8'h24;
        #1 `CHK(alert_update_fired[7], 1'b0)
        `CHK(digital_outputs[7], 1'b0)
        // Unmapped address is ignored and reads zero
        host.wr(8'h10, 8'hff);
        rd_chk(8'h10, `UNMAPPED_READ);
        rd_chk(`UPDATE_ENABLE_ADDR, 8'h80);
        // Open-drain on output 3 at level 0, digital input on channel 1
        @(posedge core_clk);
        channel_pin_mode[7:6] <= 2'b10;
        channel_pin_mode[3:2] <= 2'b01;
        channel_pin_mode[5:4] <= 2'b00;
        channel_pin_in        <= 8'h06;
        repeat (3) @(posedge core_clk);
        #1 `CHK(channel_pin_oe[3], 1'b1)
        `CHK(channel_pin_oe, 8'hf9)
        `CHK(channel_pin_out[3], 1'b0)
        `CHK(digital_inputs, 8'h02)
        // Reset in mid-run
        @(posedge core_clk);
        resetn <= 1'b0;
        @(posedge core_clk);
        resetn <= 1'b1;
        #1 `CHK(digital_outputs, 8'h00)
        rd_chk(`UPDATE_ENABLE_ADDR, 8'h00);
        rd_chk(`DRIVE_LEVEL_ADDR, 8'h00);
        rd_chk(8'(`OUT3_MASK_ADDR + 8), 8'h00);
        stop_test();
    end
endmodule : alert_triggered_output_update_tb
`default_nettype wire
